/* hw/cfg_port_pkg.sv */
// Operation
// RL1 - Device drops vector bits beyond enabled count
// RL2 - User overrides only min(capable, enabled) bits
// RL3 - Single vector: user drives request 01h
// RL4 - Thirty-two vectors: one shifted by vector
// RL5 - User checks mask register before signalling
// RL6 - MSI-X table and pending array in user
// RL7 - Nonzero class MSI goes over requester channel
// RL8 - Addresses are Dword, byte address over four
// RL9 - Read: address, function; data valid with done
// RL10 - Write: address, data, byte mask, strobe
// RL11 - Write inputs held stable until done
// RL12 - Write strobe dropped cycle after done
// RL13 - Root port override writes read-only fields
// RL14 - Override ignored in endpoint, non Type-1
// RL15 - Root port sets up space via port
// RL16 - Done is one cycle per access
// RL17 - Read strobe held; never both strobes
package cfg_port_pkg;
	localparam int ADDR_W = 10;
	localparam int FUNC_W = 8;
	localparam int FUNC_N = 2;
	localparam int SPACE_DW = 32;
	localparam int MSI_W = 32;
	localparam int CLK_NS = 100;
	localparam int WRITE_LAT_NS = 300;
	localparam int WRITE_LAT_CYC = (WRITE_LAT_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [9:0] RO_DW0 = 10'h000;
	localparam logic [9:0] RO_DW2 = 10'h002;
	localparam logic [9:0] TYPE1_HDR_LAST = 10'h00F;
	localparam logic [9:0] MSI_CTRL_DW = 10'h012;
	localparam logic [9:0] MSI_MASK_DW = 10'h014;
	localparam int MSI_EN_BIT = 16;
	localparam int MMEN_LSB = 20;
	localparam logic [2:0] MM_CAPABLE = 3'h5;
	localparam logic [31:0] SPACE_RST = 32'h0000_0000;
	// Controller register map
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] WDATA_OFS = 8'h04;
	localparam logic [7:0] RDATA_OFS = 8'h08;
	localparam logic [7:0] STATUS_OFS = 8'h0C;
	localparam logic [7:0] INT_STAT_OFS = 8'h10;
	localparam logic [7:0] INT_MASK_OFS = 8'h14;
	localparam logic [7:0] MSI_REQ_OFS = 8'h18;
	localparam int CTRL_FUNC_LSB = 10;
	localparam int CTRL_BE_LSB = 18;
	localparam int CTRL_OVR_BIT = 22;
	localparam int CTRL_RD_BIT = 24;
	localparam int CTRL_WR_BIT = 25;
	localparam logic [31:0] CTRL_KEEP = 32'h007F_FFFF;
	localparam logic [31:0] CTRL_RST = 32'h003C_0000;
	localparam int MSI_PVM_BIT = 8;
	localparam int EV_DONE = 0;
	localparam int EV_SENT = 1;
	localparam int EV_BLOCK = 2;
	localparam int EV_N = 3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	function automatic logic [31:0] be_mask(input logic [3:0] be);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++) begin
			m[i*8 +: 8] = {8{be[i]}};
		end
		return m;
	endfunction : be_mask

	// Vector bits usable: lesser of capable and enabled
	function automatic logic [2:0] msi_bits(input logic [2:0] mmen);
		return (mmen < MM_CAPABLE) ? mmen : MM_CAPABLE;
	endfunction : msi_bits
endpackage : cfg_port_pkg

/* hw/cfg_port_if.sv */
`timescale 1ns/1ns
interface cfg_port_if;
	logic [17:0] mgmt_addr;
	logic mgmt_read;
	logic mgmt_write;
	logic [31:0] write_data;
	logic [3:0] byte_enable;
	logic type1_readonly_override;
	logic [31:0] read_data;
	logic done;
	logic [2:0] msi_mmenable;
	logic [31:0] msi_int;
	logic msi_sent;

	modport device (
		input mgmt_addr,
		input mgmt_read,
		input mgmt_write,
		input write_data,
		input byte_enable,
		input type1_readonly_override,
		input msi_int,
		output read_data,
		output done,
		output msi_mmenable,
		output msi_sent
	);

	modport user (
		output mgmt_addr,
		output mgmt_read,
		output mgmt_write,
		output write_data,
		output byte_enable,
		output type1_readonly_override,
		output msi_int,
		input read_data,
		input done,
		input msi_mmenable,
		input msi_sent
	);
endinterface : cfg_port_if

/* hw/cfg_port_device.sv */
`timescale 1ns/1ns
module cfg_port_device (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic root_port_mode,
	cfg_port_if.device port,
	output logic msi_fire,
	output logic [4:0] msi_vector
);
	import cfg_port_pkg::*;

	// ----------------------------------------
	// Configuration space
	// ----------------------------------------
	logic [31:0] space_mem [FUNC_N*SPACE_DW];
	logic [9:0] addr;
	logic [7:0] func;
	logic [5:0] idx;
	logic in_range;
	logic [31:0] ro;
	logic [31:0] wmask;
	logic busy_reg;
	logic is_write_reg;
	logic [2:0] cnt_reg;

	assign addr = port.mgmt_addr[9:0];
	assign func = port.mgmt_addr[17:10];
	assign idx = {func[0], addr[4:0]};
	assign in_range = (addr < 10'(SPACE_DW)) && (func < 8'(FUNC_N));

	always_comb begin
		ro = '0;
		if (addr == RO_DW0 || addr == RO_DW2) begin
			ro = '1;
		end
		// RL13 override opens fields
		// RL14 root port Type-1 only
		if (root_port_mode && port.type1_readonly_override &&
			addr <= TYPE1_HDR_LAST) begin
			ro = '0;
		end
		wmask = be_mask(port.byte_enable) & ~ro;
	end

	// ----------------------------------------
	// Access sequencing
	// ----------------------------------------
	// Done cycle blocks retake while strobe still high
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_reg <= 1'b0;
			is_write_reg <= 1'b0;
			cnt_reg <= '0;
			port.done <= 1'b0;
		end else begin
			port.done <= 1'b0;
			if (!busy_reg && !port.done &&
				(port.mgmt_read || port.mgmt_write)) begin
				busy_reg <= 1'b1;
				is_write_reg <= port.mgmt_write;
				cnt_reg <= port.mgmt_write ? 3'(WRITE_LAT_CYC - 1) : 3'h0;
			end else if (busy_reg) begin
				if (cnt_reg == 3'h0) begin
					busy_reg <= 1'b0;
					// RL16 single-cycle done
					port.done <= 1'b1;
				end else begin
					cnt_reg <= cnt_reg - 3'h1;
				end
			end
		end
	end

	// RL10 write lands at completion
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < FUNC_N*SPACE_DW; i++) begin
				space_mem[i] <= SPACE_RST;
			end
		end else if (busy_reg && cnt_reg == 3'h0 && is_write_reg &&
			in_range) begin
			space_mem[idx] <= (space_mem[idx] & ~wmask) |
				(port.write_data & wmask);
		end
	end

	// RL9 data held with done
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.read_data <= '0;
		end else if (busy_reg && cnt_reg == 3'h0 && !is_write_reg) begin
			port.read_data <= in_range ? space_mem[idx] : '0;
		end
	end

	// ----------------------------------------
	// MSI vector path
	// ----------------------------------------
	logic [31:0] msi_ctrl;
	logic [2:0] nbits;
	logic [31:0] allow;
	logic [31:0] req_eff;
	logic [4:0] first_vec;
	logic found;
	logic msi_wait_reg;

	assign msi_ctrl = space_mem[{1'b0, MSI_CTRL_DW[4:0]}];
	assign nbits = msi_bits(msi_ctrl[MMEN_LSB +: 3]);

	always_comb begin
		// RL1 vectors past grant dropped
		allow = (nbits >= 3'h5) ? '1 :
			((32'h0000_0001 << (6'h01 << nbits)) - 32'h0000_0001);
		req_eff = port.msi_int & allow;
		first_vec = '0;
		found = 1'b0;
		for (int i = 0; i < MSI_W; i++) begin
			if (req_eff[i] && !found) begin
				first_vec = 5'(i);
				found = 1'b1;
			end
		end
	end

	// RL5 mask register never consulted
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			msi_wait_reg <= 1'b0;
			port.msi_sent <= 1'b0;
			msi_fire <= 1'b0;
			msi_vector <= '0;
		end else begin
			port.msi_sent <= 1'b0;
			msi_fire <= 1'b0;
			if (!msi_wait_reg && msi_ctrl[MSI_EN_BIT] && found) begin
				port.msi_sent <= 1'b1;
				msi_fire <= 1'b1;
				msi_vector <= first_vec;
				msi_wait_reg <= 1'b1;
			end else if (msi_wait_reg && port.msi_int == '0) begin
				msi_wait_reg <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			port.msi_mmenable <= '0;
		end else begin
			port.msi_mmenable <= msi_ctrl[MMEN_LSB +: 3];
		end
	end
endmodule : cfg_port_device

/* hw/cfg_port_user.sv */
`timescale 1ns/1ns
module cfg_port_user (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic irq,
	cfg_port_if.user port
);
	import cfg_port_pkg::*;

	typedef enum logic [1:0] {U_IDLE, U_CFG, U_MASK, U_MSI} ustate_t;

	ustate_t state_reg;
	logic [31:0] ctrl_reg;
	logic [31:0] wdata_reg;
	logic [31:0] rdata_reg;
	logic [EV_N-1:0] int_stat_reg;
	logic [EV_N-1:0] int_mask_reg;
	logic [EV_N-1:0] ev;
	logic [4:0] msi_vec_reg;
	logic pvm_reg;
	logic blocked_reg;

	// ----------------------------------------
	// AXI4-Lite slave handshake
	// ----------------------------------------
	logic wr_take;
	logic wr_fire;
	logic rd_take;
	logic rd_fire;
	logic [31:0] wm;
	logic [31:0] wnew;
	logic wr_hit;
	logic rd_hit;
	logic [31:0] rd_mux;

	assign wr_take = s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
		!s_axi_bvalid;
	assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
		s_axi_wready;
	assign rd_take = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign wm = be_mask(s_axi_wstrb);
	assign wnew = s_axi_wdata & wm;

	always_comb begin
		wr_hit = 1'b1;
		case (s_axi_awaddr)
			CTRL_OFS, WDATA_OFS, INT_STAT_OFS, INT_MASK_OFS,
			MSI_REQ_OFS: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	always_comb begin
		rd_hit = 1'b1;
		case (s_axi_araddr)
			CTRL_OFS: rd_mux = ctrl_reg;
			WDATA_OFS: rd_mux = wdata_reg;
			RDATA_OFS: rd_mux = rdata_reg;
			STATUS_OFS: rd_mux = {27'h0, blocked_reg, port.msi_mmenable,
				state_reg != U_IDLE};
			INT_STAT_OFS: rd_mux = {29'h0, int_stat_reg};
			INT_MASK_OFS: rd_mux = {29'h0, int_mask_reg};
			MSI_REQ_OFS: rd_mux = {23'h0, pvm_reg, 3'h0, msi_vec_reg};
			default: begin
				rd_mux = '0;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Write address and data taken together
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= wr_take;
			s_axi_wready <= wr_take;
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= rd_take;
			if (rd_fire) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_mux;
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	logic ctrl_wr;
	logic msi_wr;
	logic [31:0] ctrl_new;

	assign ctrl_wr = wr_fire && s_axi_awaddr == CTRL_OFS;
	assign msi_wr = wr_fire && s_axi_awaddr == MSI_REQ_OFS;
	assign ctrl_new = ((ctrl_reg & ~wm) | wnew) & CTRL_KEEP;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_reg <= CTRL_RST;
			wdata_reg <= '0;
			int_mask_reg <= '0;
		end else if (wr_fire) begin
			if (s_axi_awaddr == CTRL_OFS) begin
				ctrl_reg <= ctrl_new;
			end
			if (s_axi_awaddr == WDATA_OFS) begin
				wdata_reg <= (wdata_reg & ~wm) | wnew;
			end
			if (s_axi_awaddr == INT_MASK_OFS) begin
				int_mask_reg <= (int_mask_reg & ~wm[EV_N-1:0]) |
					wnew[EV_N-1:0];
			end
		end
	end

	// Set beats clear on the same edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			int_stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			if (wr_fire && s_axi_awaddr == INT_STAT_OFS) begin
				int_stat_reg <= (int_stat_reg & ~wnew[EV_N-1:0]) | ev;
			end else begin
				int_stat_reg <= int_stat_reg | ev;
			end
			irq <= |(int_stat_reg & int_mask_reg);
		end
	end

	// ----------------------------------------
	// MSI vector shaping
	// ----------------------------------------
	logic [2:0] nbits;
	logic [4:0] vec_lim;
	logic [31:0] onehot;

	// RL2 only granted low bits
	assign nbits = msi_bits(port.msi_mmenable);
	assign vec_lim = msi_vec_reg & (5'h1F >> (3'h5 - nbits));
	// RL3 RL4 one-hot by vector
	assign onehot = 32'h0000_0001 << vec_lim;

	// ----------------------------------------
	// Access and interrupt sequencer
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= U_IDLE;
			port.mgmt_addr <= '0;
			port.mgmt_read <= 1'b0;
			port.mgmt_write <= 1'b0;
			port.write_data <= '0;
			port.byte_enable <= '0;
			port.type1_readonly_override <= 1'b0;
			port.msi_int <= '0;
			rdata_reg <= '0;
			msi_vec_reg <= '0;
			pvm_reg <= 1'b0;
			blocked_reg <= 1'b0;
			ev <= '0;
		end else begin
			ev <= '0;
			case (state_reg)
				U_IDLE: begin
					// RL17 both strobes at once refused
					// RL15 space set up from here
					if (ctrl_wr && (wnew[CTRL_RD_BIT] ^ wnew[CTRL_WR_BIT])) begin
						// RL8 Dword address, RL9 function
						port.mgmt_addr <= ctrl_new[17:0];
						port.byte_enable <= ctrl_new[CTRL_BE_LSB +: 4];
						port.type1_readonly_override <= ctrl_new[CTRL_OVR_BIT];
						port.write_data <= wdata_reg;
						port.mgmt_read <= wnew[CTRL_RD_BIT];
						// RL10 write strobe raised
						port.mgmt_write <= wnew[CTRL_WR_BIT];
						state_reg <= U_CFG;
					end else if (msi_wr) begin
						msi_vec_reg <= wnew[4:0];
						pvm_reg <= wnew[MSI_PVM_BIT];
						blocked_reg <= 1'b0;
						if (wnew[MSI_PVM_BIT]) begin
							// RL5 fetch mask first
							port.mgmt_addr <= {8'h00, MSI_MASK_DW};
							port.mgmt_read <= 1'b1;
							state_reg <= U_MASK;
						end else begin
							state_reg <= U_MSI;
						end
					end
				end
				// RL11 inputs held until done
				U_CFG: begin
					if (port.done) begin
						// RL12 strobe drops next cycle
						port.mgmt_write <= 1'b0;
						port.mgmt_read <= 1'b0;
						port.type1_readonly_override <= 1'b0;
						if (port.mgmt_read) begin
							rdata_reg <= port.read_data;
						end
						ev[EV_DONE] <= 1'b1;
						state_reg <= U_IDLE;
					end
				end
				U_MASK: begin
					if (port.done) begin
						port.mgmt_read <= 1'b0;
						// RL5 masked vector withheld
						if (port.read_data[vec_lim]) begin
							blocked_reg <= 1'b1;
							ev[EV_BLOCK] <= 1'b1;
							state_reg <= U_IDLE;
						end else begin
							state_reg <= U_MSI;
						end
					end
				end
				// RL6 RL7 MSI-X and nonzero class elsewhere
				U_MSI: begin
					port.msi_int <= port.msi_sent ? '0 : onehot;
					if (port.msi_sent) begin
						ev[EV_SENT] <= 1'b1;
						state_reg <= U_IDLE;
					end
				end
				default: state_reg <= U_IDLE;
			endcase
		end
	end
endmodule : cfg_port_user

/* tb/cfg_port_asserts.sv */
`timescale 1ns/1ns
module cfg_port_asserts (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mgmt_read,
	input wire logic mgmt_write,
	input wire logic [17:0] mgmt_addr,
	input wire logic [31:0] write_data,
	input wire logic [3:0] byte_enable,
	input wire logic [31:0] read_data,
	input wire logic done,
	input wire logic [2:0] msi_mmenable,
	input wire logic [31:0] msi_int,
	input wire logic msi_sent
);
	logic [31:0] allow;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// Reserved enable codes grant all bits
	always_comb begin
		allow = 32'hFFFF_FFFF;
		if (msi_mmenable < 3'h5) begin
			allow = (32'h0000_0001 << (6'd1 << msi_mmenable)) - 32'h0000_0001;
		end
	end
	sequence s_rd_wait;
		!done ##[1:2] done;
	endsequence
	sequence s_wr_wait;
		!done ##1 !done ##[1:3] done;
	endsequence
	property p_rd_lat;
		$rose(mgmt_read) |-> s_rd_wait;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read done not in time");
	property p_wr_lat;
		$rose(mgmt_write) |-> s_wr_wait;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write done not in time");
	property p_done_pulse;
		done |=> !done;
	endproperty
	a_done_pulse: assert property (p_done_pulse)
		else $error("done longer than one cycle");
	property p_done_cause;
		done |-> (mgmt_read ^ mgmt_write);
	endproperty
	a_done_cause: assert property (p_done_cause)
		else $error("done without one strobe");
	property p_rdata_hold;
		$changed(read_data) |-> done && mgmt_read;
	endproperty
	a_rdata_hold: assert property (p_rdata_hold)
		else $error("read word moved outside read done");
	property p_mmen_src;
		$changed(msi_mmenable) |-> mgmt_write || $past(mgmt_write);
	endproperty
	a_mmen_src: assert property (p_mmen_src)
		else $error("enabled vectors moved without write");
	property p_msi_allow;
		msi_sent |-> ($past(msi_int) & $past(allow)) != 32'h0000_0000;
	endproperty
	a_msi_allow: assert property (p_msi_allow)
		else $error("vector sent from ungranted bits");
	property p_msi_pulse;
		msi_sent |=> !msi_sent;
	endproperty
	a_msi_pulse: assert property (p_msi_pulse)
		else $error("vector sent pulse too long");
	property p_wr_hold;
		mgmt_write && !done |=> mgmt_write && $stable(mgmt_addr) &&
			$stable(write_data) && $stable(byte_enable);
	endproperty
	a_wr_hold: assert property (p_wr_hold)
		else $error("write request moved before done");
	property p_rd_hold;
		mgmt_read && !done |=> mgmt_read && $stable(mgmt_addr);
	endproperty
	a_rd_hold: assert property (p_rd_hold)
		else $error("read request moved before done");
	property p_strobe_drop;
		done |=> !mgmt_read && !mgmt_write;
	endproperty
	a_strobe_drop: assert property (p_strobe_drop)
		else $error("strobe not dropped after done");
	property p_one_strobe;
		!(mgmt_read && mgmt_write);
	endproperty
	a_one_strobe: assert property (p_one_strobe)
		else $error("read and write strobes together");
	property p_single_vec;
		(msi_mmenable == 3'h0) && (msi_int != 32'h0000_0000) |->
			msi_int == 32'h0000_0001;
	endproperty
	a_single_vec: assert property (p_single_vec)
		else $error("single vector request not one");
	property p_msi_onehot;
		msi_int != 32'h0000_0000 |-> $onehot(msi_int);
	endproperty
	a_msi_onehot: assert property (p_msi_onehot)
		else $error("vector request not one-hot");
	property p_vec_grant;
		(msi_int & ~allow) == 32'h0000_0000;
	endproperty
	a_vec_grant: assert property (p_vec_grant)
		else $error("vector request beyond granted bits");
endmodule : cfg_port_asserts

/* tb/pcie_config_port_msi_vector_test.sv */
`timescale 1ns/1ns
module pcie_config_port_msi_vector_test;
	import cfg_port_pkg::*;
	logic aclk, aresetn, root_port_mode, irq, msi_fire;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, resp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [4:0] msi_vector, fired_vec;
	logic [31:0] space [2][32];
	int mismatches, tests_run, fires, seed;
	cfg_port_if port_bus ();
	cfg_port_device i_cfg_port_device (.aclk, .aresetn, .root_port_mode,
		.port(port_bus), .msi_fire, .msi_vector);
	cfg_port_user i_cfg_port_user (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .irq,
		.port(port_bus));
	cfg_port_asserts i_cfg_port_asserts (.aclk, .aresetn,
		.mgmt_read(port_bus.mgmt_read), .mgmt_write(port_bus.mgmt_write),
		.mgmt_addr(port_bus.mgmt_addr), .write_data(port_bus.write_data),
		.byte_enable(port_bus.byte_enable),
		.read_data(port_bus.read_data), .done(port_bus.done),
		.msi_mmenable(port_bus.msi_mmenable), .msi_int(port_bus.msi_int),
		.msi_sent(port_bus.msi_sent));

	task automatic end_of_test();
		$display("mismatches %0d tests_run %0d", mismatches, tests_run);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input string what, input logic [31:0] e,
		input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, e, g);
		end
	endtask : chk

	task automatic bound(input int n);
		if (n >= 200) begin
			mismatches++;
			$display("unexpected wait: expected answer seen none");
			end_of_test();
		end
	endtask : bound

	// --------------------------------------------------
	// Bus cycles
	// --------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1 && n < 200);
		resp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		bound(n);
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] q);
		int n;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1 && n < 200);
		q = s_axi_rdata;
		resp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		bound(n);
	endtask : axi_rd

	// Waits for an event, then clears just that event
	task automatic wait_ev(input logic [31:0] m, output logic [31:0] q);
		int n;
		n = 0;
		do begin
			axi_rd(INT_STAT_OFS, q);
			n++;
		end while ((q & m) == 0 && n < 200);
		bound(n);
		axi_wr(INT_STAT_OFS, q & m);
	endtask : wait_ev

	task automatic cfg(input bit wr, input int a, input int f,
		input logic [3:0] be, input bit ovr, input logic [31:0] d);
		logic [31:0] m, q;
		for (int i = 0; i < 4; i++) m[i*8 +: 8] = {8{be[i]}};
		axi_wr(WDATA_OFS, d);
		axi_wr(CTRL_OFS, {6'h00, wr, !wr, 1'b0, ovr, be, f[7:0], a[9:0]});
		wait_ev(32'h1, q);
		if (!wr) begin
			axi_rd(RDATA_OFS, q);
			chk("config read", (a < 32 && f < 2) ? space[f][a] : 0, q);
		end else if (a < 32 && f < 2) begin
			if (!((a == 0 || a == 2) && !(root_port_mode && ovr))) begin
				space[f][a] = (space[f][a] & ~m) | (d & m);
			end
		end
	endtask : cfg

	task automatic test_end(input string name);
		$display("test %s over", name);
	endtask : test_end

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	always @(posedge aclk) begin
		if (msi_fire === 1'b1) begin
			fires++;
			fired_vec = msi_vector;
		end
	end

	// --------------------------------------------------
	// Main sequence
	// --------------------------------------------------
	initial begin
		logic [31:0] q;
		int a, f, v;
		seed = 32'h87ef_6020;
		aresetn = 1'b0;
		root_port_mode = 1'b0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
		{s_axi_arvalid, s_axi_rready} = 2'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		for (int i = 0; i < 64; i++) space[i / 32][i % 32] = 32'h0000_0000;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		axi_rd(CTRL_OFS, q);
		chk("control reset", CTRL_RST, q);
		axi_rd(STATUS_OFS, q);
		chk("status reset", 32'h0000_0000, q);
		axi_rd(8'h1C, q);
		chk("unmapped response", RESP_SLVERR, resp);
		axi_wr(8'h1C, 32'h0000_0000);
		chk("unmapped write response", RESP_SLVERR, resp);
		test_end("reset");
		for (int i = 0; i < 12; i++) begin
			a = {$random(seed)} % 34;
			f = {$random(seed)} % 3;
			q = $random(seed);
			cfg(1, a, f, q[3:0], 0, $random(seed));
			cfg(0, a, f, 4'hF, 0, 0);
		end
		test_end("random access");
		cfg(1, 0, 0, 4'hF, 1, 32'h1234_5678);
		cfg(0, 0, 0, 4'hF, 0, 0);
		root_port_mode <= 1'b1;
		cfg(1, 2, 1, 4'hF, 0, 32'hA5A5_0F0F);
		cfg(0, 2, 1, 4'hF, 0, 0);
		cfg(1, 2, 1, 4'h5, 1, 32'hA5A5_0F0F);
		cfg(0, 2, 1, 4'hF, 0, 0);
		cfg(1, 16, 0, 4'hF, 1, 32'h0BAD_F00D);
		cfg(0, 16, 0, 4'hF, 0, 0);
		root_port_mode <= 1'b0;
		test_end("override");
		axi_wr(INT_MASK_OFS, 32'h0);
		chk("write response", RESP_OKAY, resp);
		axi_wr(CTRL_OFS, 32'h0100_0001);
		repeat (10) @(posedge aclk);
		chk("irq masked", 0, irq);
		axi_wr(INT_MASK_OFS, 32'h7);
		repeat (2) @(posedge aclk);
		chk("irq raised", 1, irq);
		axi_wr(INT_STAT_OFS, 32'h1);
		repeat (2) @(posedge aclk);
		chk("irq cleared", 0, irq);
		axi_wr(CTRL_OFS, 32'h0300_0000);
		repeat (8) @(posedge aclk);
		axi_rd(INT_STAT_OFS, q);
		chk("both strobes event", 0, q);
		axi_rd(STATUS_OFS, q);
		chk("both strobes busy", 0, q & 32'h1);
		test_end("interrupt");
		for (int m = 0; m < 6; m++) begin
			cfg(1, 18, 0, 4'hF, 0, 32'h0001_0000 | m << 20);
			chk("enabled vectors", m, port_bus.msi_mmenable);
			v = {$random(seed)} % 32;
			a = fires;
			axi_wr(MSI_REQ_OFS, v);
			wait_ev(32'h6, q);
			chk("vector sent", 32'h2, q & 32'h6);
			chk("vector index", v & ((1 << m) - 1), fired_vec);
			chk("fire count", a + 1, fires);
		end
		test_end("vectors");
		v = {$random(seed)} % 32;
		cfg(1, 20, 0, 4'hF, 0, 32'h1 << v);
		a = fires;
		axi_wr(MSI_REQ_OFS, 32'h100 | v);
		wait_ev(32'h6, q);
		chk("vector blocked", 32'h4, q & 32'h6);
		axi_rd(STATUS_OFS, q);
		chk("blocked status", 32'h1A, q & 32'h1E);
		chk("fire count", a, fires);
		axi_wr(MSI_REQ_OFS, 32'h100 | (v ^ 1));
		wait_ev(32'h6, q);
		chk("unmasked sent", 32'h2, q & 32'h6);
		test_end("vector mask");
		end_of_test();
	end
endmodule : pcie_config_port_msi_vector_test
